// ===== inc/dac_cfg_pkg.sv
// Package: constants, pin and analog-control carriers for the octal converter control block
package dac_cfg_pkg;

  // Widths and counts
  localparam int DATA_W = 12;
  localparam int ADDR_W = 5;
  localparam int NUM_CH = 8;

  // Address map: config word, channel data, zero and gain banks
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [1:0] BANK_DATA = 2'h1;
  localparam logic [1:0] BANK_ZERO = 2'h2;
  localparam logic [1:0] BANK_GAIN = 2'h3;

  // Configuration field positions
  localparam int BIT_READ_SEL = 11;
  localparam int BIT_SYNC_LOAD = 10;
  localparam int BIT_SOFT_RESET = 9;
  localparam int BIT_PD_A = 8;
  localparam int BIT_PD_B = 7;
  localparam int BIT_CAL_EN = 6;
  localparam int BIT_GBUSY = 5;
  localparam int BIT_SPAN_A = 4;
  localparam int BIT_SPAN_B = 3;

  // Reset values
  localparam logic [11:0] CONFIG_RESET = 12'h800;
  localparam logic [11:0] DATA_RESET = 12'h000;
  localparam logic [11:0] ZERO_RESET = 12'h000;
  localparam logic [11:0] GAIN_RESET = 12'h800;

  // Correction time per channel, and its cycle count at the 20 MHz clock
  localparam int CORR_TIME_NS = 500;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CORR_CYCLES = (CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // Host pins as sampled
  typedef struct packed {
    logic cs_n;
    logic rd_wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] db;
    logic async_latch_load_pin_n;
  } host_pins_s;

  // Analog-side controls
  typedef struct packed {
    logic [NUM_CH-1:0][DATA_W-1:0] latch;
    logic [NUM_CH-1:0] output_enable;
    logic power_down_group_a;
    logic power_down_group_b;
    logic span_sel_a;
    logic span_sel_b;
    logic offset_reload_a;
    logic offset_reload_b;
    logic global_correction_busy;
  } analog_ctrl_s;

endpackage : dac_cfg_pkg

// ===== rtl/octal_dac_config_control.sv
// Configuration register, correction engine and latch control of the octal converter
// How it works
// - Readback bit picks input or corrected data
// - Calibration keeps raw input, corrected word separate
// - Sync load copies data registers into latches
// - Loads refresh only channels written since last
// - Sync load bit clears after its update
// - Sync load writes ignored while load pin low
// - Calibration off: sync load updates latches two cycles after the chip-select rise is detected
// - Soft reset equals hardware reset, reads zero
// - Group A power-down disables channels 0-3
// - Group B power-down disables channels 4-7
// - Calibration corrects input with gain and zero
// - Calibration off: input passes straight through
// - Busy flag high while any channel pending
// - Busy flag zero when calibration disabled
// - Group A span bit selects x6 or x4
// - Group A span change reloads offset trim
// - Group B span bit selects x6 or x4
// - Group B span change reloads offset trim
// - Low three config bits ignore writes, read zero
// - Reset leaves only readback bit set
// - Each channel correction takes about 500 ns
`timescale 1ns/1ps
`default_nettype none

module octal_dac_config_control #(
  parameter int CORR_COUNT = dac_cfg_pkg::CORR_CYCLES
) (
  // Clock, reset, clock enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Host parallel pins and load pin
  input wire dac_cfg_pkg::host_pins_s pins,
  output logic [dac_cfg_pkg::DATA_W-1:0] db_out,
  output logic db_oe,
  // Analog-side controls
  output dac_cfg_pkg::analog_ctrl_s analog
);
  import dac_cfg_pkg::*;

  // Whole module state
  typedef struct packed {
    host_pins_s s1;
    host_pins_s s2;
    host_pins_s s3;
    logic cs_n_stable;
    logic load_n_stable;
    logic read_sel;
    logic sync_latch_update;
    logic power_down_group_a;
    logic power_down_group_b;
    logic calibration_engine_enable;
    logic span_a;
    logic span_b;
    logic [NUM_CH-1:0][DATA_W-1:0] input_data;
    logic [NUM_CH-1:0][DATA_W-1:0] dac_data;
    logic [NUM_CH-1:0][DATA_W-1:0] zero;
    logic [NUM_CH-1:0][DATA_W-1:0] gain;
    logic [NUM_CH-1:0][DATA_W-1:0] latch;
    logic [NUM_CH-1:0] accessed;
    logic [NUM_CH-1:0] channel_correction_busy;
    logic eng_active;
    logic [2:0] eng_ch;
    logic [CNT_W-1:0] eng_cnt;
    logic [DATA_W-1:0] rd_data;
    logic reload_a;
    logic reload_b;
  } state_s;

  // Reset image of the state
  function automatic state_s reset_state();
    state_s r;
    r = '0;
    // Idle pin image, so no false edge follows reset
    r.s1.cs_n = 1'b1;
    r.s2.cs_n = 1'b1;
    r.s3.cs_n = 1'b1;
    r.s1.async_latch_load_pin_n = 1'b1;
    r.s2.async_latch_load_pin_n = 1'b1;
    r.s3.async_latch_load_pin_n = 1'b1;
    r.cs_n_stable = 1'b1;
    r.load_n_stable = 1'b1;
    r.read_sel = CONFIG_RESET[BIT_READ_SEL];
    r.sync_latch_update = CONFIG_RESET[BIT_SYNC_LOAD];
    r.power_down_group_a = CONFIG_RESET[BIT_PD_A];
    r.power_down_group_b = CONFIG_RESET[BIT_PD_B];
    r.calibration_engine_enable = CONFIG_RESET[BIT_CAL_EN];
    r.span_a = CONFIG_RESET[BIT_SPAN_A];
    r.span_b = CONFIG_RESET[BIT_SPAN_B];
    // Data, zero, gain and latch defaults
    for (int i = 0; i < NUM_CH; i++) begin
      r.input_data[i] = DATA_RESET;
      r.dac_data[i] = DATA_RESET;
      r.zero[i] = ZERO_RESET;
      r.gain[i] = GAIN_RESET;
      r.latch[i] = DATA_RESET;
    end
    return r;
  endfunction : reset_state

  // Gain then signed zero offset, clamped to the code range
  function automatic logic [DATA_W-1:0] correct(input logic [DATA_W-1:0] din,
                                                input logic [DATA_W-1:0] g,
                                                input logic [DATA_W-1:0] z);
    logic [25:0] prod;
    logic signed [15:0] sum;
    prod = {14'h0000, din} * {13'h0000, 13'(g) + 13'h0800};
    sum = $signed({2'b00, prod[25:12]}) + 16'($signed(z));
    // Clamp to the code range
    if (sum < 0) begin
      correct = 12'h000;
    end else if (sum > 16'sh0fff) begin
      correct = 12'hfff;
    end else begin
      correct = sum[DATA_W-1:0];
    end
  endfunction : correct

  // Configuration word as read back
  function automatic logic [DATA_W-1:0] config_word(input state_s s, input logic gbusy);
    logic [DATA_W-1:0] w;
    // Reserved bits stay zero
    w = '0;
    w[BIT_READ_SEL] = s.read_sel;
    w[BIT_SYNC_LOAD] = s.sync_latch_update;
    w[BIT_SOFT_RESET] = 1'b0;
    w[BIT_PD_A] = s.power_down_group_a;
    w[BIT_PD_B] = s.power_down_group_b;
    w[BIT_CAL_EN] = s.calibration_engine_enable;
    w[BIT_GBUSY] = gbusy;
    w[BIT_SPAN_A] = s.span_a;
    w[BIT_SPAN_B] = s.span_b;
    return w;
  endfunction : config_word

  // Registered state and its next value
  state_s st_ff;
  state_s nxt_st;

  // Decode and engine helpers
  logic global_correction_busy;
  logic cs_rise;
  logic load_fall;
  logic wr_strobe;
  logic do_load;
  logic [2:0] wch;
  logic [1:0] wbank;
  logic [DATA_W-1:0] wdata;
  logic [NUM_CH-1:0] set_busy;
  logic [NUM_CH-1:0] set_access;
  logic [2:0] pick;
  logic found;
  logic sync_req;

  // Busy flag only while calibration enabled
  assign global_correction_busy = st_ff.calibration_engine_enable &
                                  (|st_ff.channel_correction_busy);

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    set_busy = '0;
    set_access = '0;
    pick = 3'h0;
    found = 1'b0;
    do_load = 1'b0;
    sync_req = 1'b0;
    // Three-stage pin sampling, change accepted when stages two and three agree
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2.cs_n == st_ff.s3.cs_n) begin
      nxt_st.cs_n_stable = st_ff.s3.cs_n;
    end
    if (st_ff.s2.async_latch_load_pin_n == st_ff.s3.async_latch_load_pin_n) begin
      nxt_st.load_n_stable = st_ff.s3.async_latch_load_pin_n;
    end
    // Edges and write strobe from the agreeing stages
    cs_rise = !st_ff.cs_n_stable && st_ff.s2.cs_n && st_ff.s3.cs_n;
    load_fall = st_ff.load_n_stable && !st_ff.s2.async_latch_load_pin_n &&
                !st_ff.s3.async_latch_load_pin_n;
    wr_strobe = cs_rise && !st_ff.s3.rd_wr_n;
    // Write address, bank and data from stage three
    wch = st_ff.s3.addr[2:0];
    wbank = st_ff.s3.addr[4:3];
    wdata = st_ff.s3.db;
    // Trim reload pulses last one cycle
    nxt_st.reload_a = 1'b0;
    nxt_st.reload_b = 1'b0;

    // Correction engine: one channel at a time, lowest pending first
    if (!st_ff.calibration_engine_enable) begin
      // Calibration turned off: pending channels take their raw input
      for (int i = 0; i < NUM_CH; i++) begin
        if (st_ff.channel_correction_busy[i]) begin
          nxt_st.dac_data[i] = st_ff.input_data[i];
        end
      end
      nxt_st.channel_correction_busy = '0;
      nxt_st.eng_active = 1'b0;
    end else if (st_ff.eng_active) begin
      if (st_ff.eng_cnt == '0) begin
        nxt_st.dac_data[st_ff.eng_ch] = correct(st_ff.input_data[st_ff.eng_ch],
                                                st_ff.gain[st_ff.eng_ch],
                                                st_ff.zero[st_ff.eng_ch]);
        nxt_st.channel_correction_busy[st_ff.eng_ch] = 1'b0;
        nxt_st.eng_active = 1'b0;
      end else begin
        nxt_st.eng_cnt = st_ff.eng_cnt - 1'b1;
      end
    end else begin
      // Lowest pending channel wins
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (st_ff.channel_correction_busy[i]) begin
          pick = 3'(i);
          found = 1'b1;
        end
      end
      if (found) begin
        nxt_st.eng_active = 1'b1;
        nxt_st.eng_ch = pick;
        nxt_st.eng_cnt = CNT_W'(CORR_COUNT - 1);
      end
    end

    // Host writes, taken at the chip-select rising edge
    if (wr_strobe) begin
      if (st_ff.s3.addr == ADDR_CONFIG) begin
        // Config fields; the sync request is applied after the load logic
        nxt_st.read_sel = wdata[BIT_READ_SEL];
        if (st_ff.load_n_stable && wdata[BIT_SYNC_LOAD]) begin
          sync_req = 1'b1;
        end
        nxt_st.power_down_group_a = wdata[BIT_PD_A];
        nxt_st.power_down_group_b = wdata[BIT_PD_B];
        nxt_st.calibration_engine_enable = wdata[BIT_CAL_EN];
        nxt_st.span_a = wdata[BIT_SPAN_A];
        nxt_st.span_b = wdata[BIT_SPAN_B];
        nxt_st.reload_a = wdata[BIT_SPAN_A] != st_ff.span_a;
        nxt_st.reload_b = wdata[BIT_SPAN_B] != st_ff.span_b;
      end else if (wbank == BANK_DATA) begin
        // Data write: raw word kept, corrected copy pending while calibration is enabled, else copied straight
        set_access[wch] = 1'b1;
        if (st_ff.calibration_engine_enable) begin
          nxt_st.input_data[wch] = wdata;
          set_busy[wch] = 1'b1;
        end else begin
          nxt_st.input_data[wch] = wdata;
          nxt_st.dac_data[wch] = wdata;
        end
      end else if (wbank == BANK_ZERO) begin
        // Calibration word write re-queues the channel while calibration is enabled
        nxt_st.zero[wch] = wdata;
        set_access[wch] = 1'b1;
        set_busy[wch] = st_ff.calibration_engine_enable;
      end else if (wbank == BANK_GAIN) begin
        nxt_st.gain[wch] = wdata;
        set_access[wch] = 1'b1;
        set_busy[wch] = st_ff.calibration_engine_enable;
      end
    end

    // Latch update from the pin edge or a pending sync load once idle
    if (load_fall) begin
      do_load = 1'b1;
    end else if (st_ff.sync_latch_update && !global_correction_busy) begin
      do_load = 1'b1;
    end
    // Copy only accessed channels, then clear the marks
    if (do_load) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (st_ff.accessed[i]) begin
          nxt_st.latch[i] = nxt_st.dac_data[i];
        end
      end
      nxt_st.accessed = '0;
      nxt_st.sync_latch_update = 1'b0;
    end
    // Load pin held low drops a pending sync load
    if (!st_ff.load_n_stable) begin
      nxt_st.sync_latch_update = 1'b0;
    end
    // A new sync request wins over the clear of the same cycle
    if (sync_req) begin
      nxt_st.sync_latch_update = 1'b1;
    end
    // New writes win over clears in the same cycle
    nxt_st.accessed = nxt_st.accessed | set_access;
    nxt_st.channel_correction_busy = nxt_st.channel_correction_busy |
                                     (set_busy & {NUM_CH{nxt_st.calibration_engine_enable}});

    // Read data, reloaded every cycle while a read cycle is selected, held otherwise
    if (!st_ff.cs_n_stable && st_ff.s3.rd_wr_n) begin
      if (st_ff.s3.addr == ADDR_CONFIG) begin
        nxt_st.rd_data = config_word(st_ff, global_correction_busy);
      end else if (st_ff.s3.addr[4:3] == BANK_DATA) begin
        nxt_st.rd_data = st_ff.read_sel ? st_ff.dac_data[st_ff.s3.addr[2:0]]
                                        : st_ff.input_data[st_ff.s3.addr[2:0]];
      end else if (st_ff.s3.addr[4:3] == BANK_ZERO) begin
        nxt_st.rd_data = st_ff.zero[st_ff.s3.addr[2:0]];
      end else if (st_ff.s3.addr[4:3] == BANK_GAIN) begin
        nxt_st.rd_data = st_ff.gain[st_ff.s3.addr[2:0]];
      end else begin
        nxt_st.rd_data = '0;
      end
    end

    // Software reset restores the whole reset image
    if (wr_strobe && st_ff.s3.addr == ADDR_CONFIG && wdata[BIT_SOFT_RESET]) begin
      nxt_st = reset_state();
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= reset_state();
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Data bus drive while a read cycle is selected
  assign db_out = st_ff.rd_data;
  assign db_oe = !st_ff.cs_n_stable && st_ff.s3.rd_wr_n;

  // Analog-side controls
  always_comb begin
    analog.latch = st_ff.latch;
    analog.output_enable = {{4{!st_ff.power_down_group_b}},
                            {4{!st_ff.power_down_group_a}}};
    analog.power_down_group_a = st_ff.power_down_group_a;
    analog.power_down_group_b = st_ff.power_down_group_b;
    analog.span_sel_a = st_ff.span_a;
    analog.span_sel_b = st_ff.span_b;
    analog.offset_reload_a = st_ff.reload_a;
    analog.offset_reload_b = st_ff.reload_b;
    analog.global_correction_busy = global_correction_busy;
  end

endmodule : octal_dac_config_control

`default_nettype wire

// ===== bench/octal_dac_config_control_sva.sv
// Port checker for the octal converter control block
`timescale 1ns/1ps
`default_nettype none
module octal_dac_config_control_sva #(
  parameter int CORR_COUNT = 10
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Host pins
  input wire dac_cfg_pkg::host_pins_s pins,
  input wire logic [dac_cfg_pkg::DATA_W-1:0] db_out,
  input wire logic db_oe,
  // Analog side
  input wire dac_cfg_pkg::analog_ctrl_s analog
);
  import dac_cfg_pkg::*;
  localparam int BUSY_MAX = 8 * (CORR_COUNT + 1) + 40;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !ce);
  // Buffers follow the power-down levels
  pd_group_a_a: assert property (
    $stable(analog.power_down_group_a) |-> analog.output_enable[3:0] == {4{!analog.power_down_group_a}})
    else $error("group a buffers wrong");
  pd_group_b_a: assert property (
    $stable(analog.power_down_group_b) |-> analog.output_enable[7:4] == {4{!analog.power_down_group_b}})
    else $error("group b buffers wrong");
  // Trim reload only after a span change
  trim_reload_a_a: assert property (
    analog.offset_reload_a |-> analog.span_sel_a != $past(analog.span_sel_a, 2))
    else $error("group a reload without span change");
  trim_reload_b_a: assert property (
    analog.offset_reload_b |-> analog.span_sel_b != $past(analog.span_sel_b, 2))
    else $error("group b reload without span change");
  // Read drives the bus, busy drains, loads wait
  read_drive_a: assert property (
    (!pins.cs_n && pins.rd_wr_n) [*6] |-> db_oe)
    else $error("read not driven");
  busy_bound_a: assert property (
    $rose(analog.global_correction_busy) |-> ##[1:BUSY_MAX] !analog.global_correction_busy)
    else $error("busy never clears");
  load_defer_a: assert property (
    $past(analog.global_correction_busy) && analog.global_correction_busy &&
      $past(pins.async_latch_load_pin_n, 3) |-> $stable(analog.latch))
    else $error("latch moved while busy");
  cfg_zero_bits_a: assert property (
    db_oe && $past(db_oe, 2) && pins.addr == ADDR_CONFIG |-> db_out[2:0] == 3'h0 && !db_out[BIT_SOFT_RESET])
    else $error("config reserved bits not zero");
  reset_state_a: assert property (
    $fell(reset) |-> analog.latch == '0 && analog.output_enable == 8'hff)
    else $error("reset state wrong");
  // Main scenarios reached
  cov_busy_c: cover property ($rose(analog.global_correction_busy));
  cov_reload_c: cover property (analog.offset_reload_a);
  cov_latch_c: cover property (!$stable(analog.latch));
endmodule : octal_dac_config_control_sva

bind octal_dac_config_control octal_dac_config_control_sva #(.CORR_COUNT(CORR_COUNT)) sva_i (
  .mclk(mclk), .reset(reset), .ce(ce), .pins(pins), .db_out(db_out), .db_oe(db_oe), .analog(analog));
`default_nettype wire

// ===== bench/host_bus_model.sv
// Host processor model for the parallel register pins
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input wire logic mclk,
  // Pins and read answer
  output var dac_cfg_pkg::host_pins_s pins,
  input wire logic [dac_cfg_pkg::DATA_W-1:0] db_out,
  input wire logic db_oe
);
  import dac_cfg_pkg::*;
  // Idle pins
  initial pins = '{cs_n: 1'b1, rd_wr_n: 1'b1, addr: 5'h00, db: 12'h000, async_latch_load_pin_n: 1'b1};
  // One bus access; a read waits for the drive and takes data one edge later
  task automatic xfer(input logic [4:0] a, input logic [11:0] d, input logic rd, output logic [11:0] q);
    int n;
    q = 12'h000;
    n = 0;
    @(posedge mclk);
    pins.cs_n <= 1'b0;
    pins.rd_wr_n <= rd;
    pins.addr <= a;
    pins.db <= rd ? ~pins.db : d;
    repeat (5) @(posedge mclk);
    while (rd && db_oe !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (rd) begin
      @(posedge mclk);
      q = db_out;
    end
    pins.cs_n <= 1'b0 ^ 1'b1;
    repeat (6) @(posedge mclk);
    pins.db <= ~pins.db;
  endtask : xfer
  // Load pin level change, held long enough to be seen
  task automatic set_load(input logic b);
    @(posedge mclk);
    pins.async_latch_load_pin_n <= b;
    repeat (6) @(posedge mclk);
  endtask : set_load
endmodule : host_bus_model
`default_nettype wire

// ===== bench/octal_dac_config_control_tb.sv
// Self-checking bench for the octal converter control block
`timescale 1ns/1ps
`default_nettype none
module octal_dac_config_control_tb;
  import dac_cfg_pkg::*;
  localparam int CORR = 40;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  host_pins_s pins;
  logic [DATA_W-1:0] db_out;
  logic db_oe;
  analog_ctrl_s analog;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'heaba;
  int cfg, inp[8], dat[8], lat[8], zr[8], gn[8], acc[8];
  logic [11:0] q;
  // Clock
  always #25 mclk = ~mclk;
  // Device and host
  octal_dac_config_control #(.CORR_COUNT(CORR)) octal_dac_config_control_i (.mclk(mclk), .reset(reset),
    .ce(ce), .pins(pins), .db_out(db_out), .db_oe(db_oe), .analog(analog));
  host_bus_model host_bus_model_i (.mclk(mclk), .pins(pins), .db_out(db_out), .db_oe(db_oe));
  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int corr(int v, int z, int g);
    int r;
    r = (v * (2048 + g)) / 4096 + (z >= 2048 ? z - 4096 : z);
    return r < 0 ? 0 : (r > 4095 ? 4095 : r);
  endfunction : corr
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic model_reset();
    cfg = 'h800;
    for (int n = 0; n < 8; n++) begin
      inp[n] = 0;
      dat[n] = 0;
      lat[n] = 0;
      zr[n] = 0;
      gn[n] = 12'h800;
      acc[n] = 0;
    end
  endtask : model_reset
  task automatic load();
    for (int n = 0; n < 8; n++) begin
      if (acc[n] != 0) lat[n] = dat[n];
      acc[n] = 0;
    end
  endtask : load
  // Register write on the pins, mirrored into the model
  task automatic wr(int a, int v);
    host_bus_model_i.xfer(a[4:0], v[11:0], 1'b0, q);
    if (a == 0 && v[9]) model_reset();
    else if (a == 0) begin
      cfg = v & 'h9d8;
      if (v[10] && pins.async_latch_load_pin_n) load();
    end else if (a < 16) begin
      inp[a-8] = v;
      dat[a-8] = cfg[6] ? corr(v, zr[a-8], gn[a-8]) : v;
      acc[a-8] = 1;
    end else begin
      if (a < 24) zr[a%8] = v;
      else gn[a%8] = v;
      if (cfg[6]) begin
        dat[a%8] = corr(inp[a%8], zr[a%8], gn[a%8]);
        acc[a%8] = 1;
      end
    end
  endtask : wr
  task automatic rd(int a, int e);
    host_bus_model_i.xfer(a[4:0], 12'h000, 1'b1, q);
    chk(q, e[11:0]);
  endtask : rd
  task automatic lat_chk();
    for (int n = 0; n < 8; n++) chk(analog.latch[n], lat[n][11:0]);
  endtask : lat_chk
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    model_reset();
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(0, cfg);
    lat_chk();
    $display("test defaults done");
    for (int i = 0; i < 6; i++) begin
      wr(0, rnd() & 'h9ff);
      rd(0, cfg);
      chk({analog.span_sel_a, analog.span_sel_b}, {cfg[4], cfg[3]});
      chk(analog.output_enable, {{4{~cfg[7]}}, {4{~cfg[8]}}});
    end
    $display("test config done");
    wr(0, 'h000);
    for (int n = 0; n < 8; n++) wr(8 + n, rnd() & 'hfff);
    for (int n = 0; n < 8; n++) rd(8 + n, inp[n]);
    lat_chk();
    wr(0, 'hc00);
    rd(0, cfg);
    lat_chk();
    for (int n = 0; n < 8; n++) rd(8 + n, dat[n]);
    // Clock enable low: a write on the pins is lost
    ce <= 1'b0;
    host_bus_model_i.xfer(5'h08, ~dat[0][11:0], 1'b0, q);
    ce <= 1'b1;
    rd(8, dat[0]);
    $display("test passthru done");
    host_bus_model_i.set_load(1'b0);
    wr(12, rnd() & 'hfff);
    wr(0, 'hc00);
    lat_chk();
    host_bus_model_i.set_load(1'b1);
    wr(0, 'hc00);
    lat_chk();
    wr(13, rnd() & 'hfff);
    host_bus_model_i.set_load(1'b0);
    load();
    lat_chk();
    host_bus_model_i.set_load(1'b1);
    $display("test loads done");
    wr(0, 'h840);
    wr(17, rnd() & 'hfff);
    repeat (2 * CORR) @(posedge mclk);
    wr(9, rnd() & 'hfff);
    chk(analog.global_correction_busy, 1'b1);
    wr(0, 'hc40);
    repeat (3 * CORR) @(posedge mclk);
    lat_chk();
    rd(9, dat[1]);
    // Gain word joins the correction
    wr(25, rnd() & 'hfff);
    repeat (2 * CORR) @(posedge mclk);
    rd(9, dat[1]);
    rd(17, zr[1]);
    rd(25, gn[1]);
    wr(0, 'h040);
    rd(9, inp[1]);
    wr(10, rnd() & 'hfff);
    wr(0, 'h800);
    chk(analog.global_correction_busy, 1'b0);
    $display("test calib done");
    wr(0, 'h200);
    rd(0, cfg);
    lat_chk();
    chk(analog.output_enable, 8'hff);
    rd(3, 0);
    $display("test softreset done");
    tally_and_finish();
  end
endmodule : octal_dac_config_control_tb
`default_nettype wire
